// file: logic/ngp_device.sv
`timescale 1ns/1ps
module ngp_device (
   input  wire logic        CLOCK_IN,        // 250 MHz clock
   input  wire logic        RSTN_IN,         // Async hardware reset, active low
   input  wire logic        CE_IN,           // Clock enable
   input  wire logic        SW_RESET_IN,     // Software reset, sync pulse
   input  wire logic        PAR_FAULT_IN,    // Parallel detection fault level
   input  wire logic [4:0]  REG_ADDR_IN,     // Register address
   input  wire logic [15:0] REG_WDATA_IN,    // Write data
   input  wire logic        REG_WR_IN,       // Write strobe
   input  wire logic        REG_RD_IN,       // Read strobe
   output logic      [15:0] REG_RDATA_OUT,   // Read data
   output logic             REG_RVALID_OUT,  // Read data valid pulse
   ngp_link_if.dev          LINK             // Link to partner end
);

   typedef struct packed {
      logic [15:0]            base_ability;
      logic [15:0]            partner_np;
      logic                   an_able;
      logic                   page_rcvd;
      logic                   local_np;
      logic                   partner_np_able;
      logic                   par_fault;
      logic [10:0]            np_field;
      logic                   toggle;
      logic                   ack2;
      logic                   msg_page;
      logic                   np_more;
      ngp_pkg::ngp_tx_state_t tx;
      logic [15:0]            rdata;
      logic                   rvalid;
   } ngp_dev_state_t;

   ngp_dev_state_t st;
   ngp_dev_state_t next_st;

   // ***********************************************************
   // Reset values
   // ***********************************************************
   function automatic ngp_dev_state_t reset_state(input logic hw);
      ngp_dev_state_t r;
      r          = '0;
      r.np_field = ngp_pkg::NP_FIELD_RESET;
      r.msg_page = ngp_pkg::MSG_PAGE_RESET;
      r.tx       = ngp_pkg::NGP_TX_IDLE;
      // Only the local next page bit differs between the two resets
      r.local_np = hw ? ngp_pkg::LOCAL_NP_HW_RST : ngp_pkg::LOCAL_NP_SW_RST;
      return r;
   endfunction : reset_state

   // ***********************************************************
   // Hardware reset image
   // ***********************************************************
   // A constant keeps the async reset branch free of logic
   localparam ngp_dev_state_t HW_RESET_ST = reset_state(1'b1);

   // ***********************************************************
   // Register views
   // ***********************************************************
   function automatic logic [15:0] expansion_word(input ngp_dev_state_t s);
      logic [15:0] w;
      w    = ngp_pkg::WORD_ZERO;
      w[0] = s.an_able;
      w[1] = s.page_rcvd;
      w[2] = s.local_np;
      w[3] = s.partner_np_able;
      w[4] = s.par_fault;
      return w;
   endfunction : expansion_word

   function automatic logic [15:0] np_tx_word(input ngp_dev_state_t s);
      logic [15:0] w;
      w                              = ngp_pkg::WORD_ZERO;
      w[ngp_pkg::FIELD_MSB:0]        = s.np_field;
      w[ngp_pkg::BIT_TOGGLE]         = s.toggle;
      w[ngp_pkg::BIT_ACK2]           = s.ack2;
      w[ngp_pkg::BIT_MSG_PAGE]       = s.msg_page;
      w[ngp_pkg::BIT_NEXT_PAGE]      = s.np_more;
      return w;
   endfunction : np_tx_word

   function automatic logic [15:0] read_mux(input logic [4:0]     addr,
                                            input ngp_dev_state_t s);
      logic [15:0] w;
      w = ngp_pkg::WORD_ZERO;
      case (addr)
         ngp_pkg::REG_PARTNER_BASE: begin
            w = s.base_ability;
         end
         ngp_pkg::REG_EXPANSION: begin
            w = expansion_word(s);
         end
         ngp_pkg::REG_NP_TRANSMIT: begin
            w = np_tx_word(s);
         end
         ngp_pkg::REG_PARTNER_NP: begin
            w = s.partner_np;
         end
         default: begin
            // Unmapped addresses read as zero
            w = ngp_pkg::WORD_ZERO;
         end
      endcase
      return w;
   endfunction : read_mux

   // ***********************************************************
   // Next state
   // ***********************************************************
   always_comb begin
      next_st           = st;
      next_st.rvalid    = 1'b0;
      next_st.an_able   = LINK.an_able;
      next_st.par_fault = PAR_FAULT_IN;

      // Read: data from the state before this cycle's events
      if (REG_RD_IN) begin
         next_st.rdata  = read_mux(REG_ADDR_IN, st);
         next_st.rvalid = 1'b1;
         if (REG_ADDR_IN == ngp_pkg::REG_EXPANSION) begin
            next_st.page_rcvd = 1'b0;
         end
      end

      // Received pages; a new page set after the clear wins
      if (LINK.rx_valid) begin
         next_st.page_rcvd = 1'b1;
         if (LINK.rx_base) begin
            // Reserved bit 12 is dropped so it always reads zero
            next_st.base_ability    = LINK.rx_word & ngp_pkg::BASE_KEEP_MASK;
            next_st.partner_np_able = LINK.rx_word[ngp_pkg::BIT_NEXT_PAGE];
         end else begin
            next_st.partner_np = LINK.rx_word;
         end
      end

      // Offer handshake; toggle flips once per page taken
      case (st.tx)
         ngp_pkg::NGP_TX_IDLE: begin
            next_st.tx = ngp_pkg::NGP_TX_IDLE;
         end
         ngp_pkg::NGP_TX_OFFER: begin
            if (LINK.tx_taken) begin
               next_st.toggle = ~st.toggle;
               next_st.tx     = ngp_pkg::NGP_TX_IDLE;
            end
         end
         default: begin
            next_st.tx = ngp_pkg::NGP_TX_IDLE;
         end
      endcase

      // A write to REG_NP_TRANSMIT always starts a fresh offer, even over one in flight;
      // software is expected to wait for page received first
      if (REG_WR_IN && (REG_ADDR_IN == ngp_pkg::REG_NP_TRANSMIT)) begin
         next_st.np_field = REG_WDATA_IN[ngp_pkg::FIELD_MSB:0];
         next_st.ack2     = REG_WDATA_IN[ngp_pkg::BIT_ACK2];
         next_st.msg_page = REG_WDATA_IN[ngp_pkg::BIT_MSG_PAGE];
         next_st.np_more  = REG_WDATA_IN[ngp_pkg::BIT_NEXT_PAGE];
         next_st.tx       = ngp_pkg::NGP_TX_OFFER;
      end

      // Software reset overrides everything in the same cycle
      if (SW_RESET_IN) begin
         next_st = reset_state(1'b0);
      end
   end

   // ***********************************************************
   // State register
   // ***********************************************************
   always_ff @(posedge CLOCK_IN or negedge RSTN_IN) begin
      if (!RSTN_IN) begin
         st <= HW_RESET_ST;
      end else if (CE_IN) begin
         st <= next_st;
      end
   end

   // ***********************************************************
   // Outputs
   // ***********************************************************
   assign REG_RDATA_OUT  = st.rdata;
   assign REG_RVALID_OUT = st.rvalid;
   assign LINK.tx_word   = np_tx_word(st);
   assign LINK.tx_valid  = (st.tx == ngp_pkg::NGP_TX_OFFER);

endmodule : ngp_device

// file: logic/ngp_link_if.sv
`timescale 1ns/1ps
interface ngp_link_if;
   logic [15:0] rx_word;   // Code word from partner
   logic        rx_valid;  // One-cycle strobe for rx_word
   logic        rx_base;   // rx_word is a base page
   logic        an_able;   // Partner runs auto-negotiation
   logic [15:0] tx_word;   // Local next page code word
   logic        tx_valid;  // tx_word offered
   logic        tx_taken;  // One-cycle strobe: partner took tx_word

   modport dev (
      input  rx_word, rx_valid, rx_base, an_able, tx_taken,
      output tx_word, tx_valid
   );

   modport part (
      output rx_word, rx_valid, rx_base, an_able, tx_taken,
      input  tx_word, tx_valid
   );
endinterface : ngp_link_if

// file: logic/ngp_partner.sv
`timescale 1ns/1ps
module ngp_partner (
   input  wire logic        CLOCK_IN,        // 250 MHz clock
   input  wire logic        RSTN_IN,         // Async reset, active low
   input  wire logic        CE_IN,           // Clock enable
   input  wire logic        AN_ENABLE_IN,    // Partner negotiation enabled
   input  wire logic        SEND_IN,         // Send SEND_WORD_IN, pulse
   input  wire logic        SEND_BASE_IN,    // Word is a base page
   input  wire logic [15:0] SEND_WORD_IN,    // Code word to send
   output logic      [15:0] GOT_WORD_OUT,    // Last local next page taken
   output logic             GOT_VALID_OUT,   // Pulse with GOT_WORD_OUT
   ngp_link_if.part         LINK             // Link to device end
);

   typedef struct packed {
      logic [15:0]              rx_word;
      logic                     rx_valid;
      logic                     rx_base;
      logic                     an_able;
      logic                     taken;
      logic [15:0]              got_word;
      logic                     got_valid;
      ngp_pkg::ngp_take_state_t take;
   } ngp_part_state_t;

   ngp_part_state_t st;
   ngp_part_state_t next_st;

   // ***********************************************************
   // Next state
   // ***********************************************************
   always_comb begin
      next_st           = st;
      next_st.rx_valid  = 1'b0;
      next_st.taken     = 1'b0;
      next_st.got_valid = 1'b0;
      next_st.an_able   = AN_ENABLE_IN;
      if (SEND_IN) begin
         next_st.rx_word  = SEND_WORD_IN;
         next_st.rx_base  = SEND_BASE_IN;
         next_st.rx_valid = 1'b1;
      end
      case (st.take)
         ngp_pkg::NGP_P_READY: begin
            // The whole tx_word is read here: message field, toggle, ack2, message page and next page
            if (LINK.tx_valid) begin
               next_st.taken     = 1'b1;
               next_st.got_word  = LINK.tx_word;
               next_st.got_valid = 1'b1;
               next_st.take      = ngp_pkg::NGP_P_WAIT;
            end
         end
         ngp_pkg::NGP_P_WAIT: begin
            // Hold off until the offer drops so one page is taken once
            if (!LINK.tx_valid) begin
               next_st.take = ngp_pkg::NGP_P_READY;
            end
         end
         default: begin
            next_st.take = ngp_pkg::NGP_P_READY;
         end
      endcase
   end

   // ***********************************************************
   // State register
   // ***********************************************************
   always_ff @(posedge CLOCK_IN or negedge RSTN_IN) begin
      if (!RSTN_IN) begin
         st      <= '0;
         st.take <= ngp_pkg::NGP_P_READY;
      end else if (CE_IN) begin
         st <= next_st;
      end
   end

   assign LINK.rx_word   = st.rx_word;
   assign LINK.rx_valid  = st.rx_valid;
   assign LINK.rx_base   = st.rx_base;
   assign LINK.an_able   = st.an_able;
   assign LINK.tx_taken  = st.taken;
   assign GOT_WORD_OUT   = st.got_word;
   assign GOT_VALID_OUT  = st.got_valid;

endmodule : ngp_partner

// file: logic/ngp_pkg.sv
package ngp_pkg;

   // ***********************************************************
   // Widths and register addresses
   // ***********************************************************
   localparam int          WORD_W           = 16;
   localparam int          ADDR_W           = 5;
   localparam logic [4:0]  REG_PARTNER_BASE = 5'h05;
   localparam logic [4:0]  REG_EXPANSION    = 5'h06;
   localparam logic [4:0]  REG_NP_TRANSMIT  = 5'h07;
   localparam logic [4:0]  REG_PARTNER_NP   = 5'h08;

   // ***********************************************************
   // Code word field positions
   // ***********************************************************
   localparam int          FIELD_MSB        = 10;
   localparam int          BIT_TOGGLE       = 11;
   localparam int          BIT_ACK2         = 12;
   localparam int          BIT_MSG_PAGE     = 13;
   localparam int          BIT_ACK          = 14;
   localparam int          BIT_NEXT_PAGE    = 15;
   localparam int          BIT_BASE_RSVD    = 12;
   localparam logic [15:0] BASE_KEEP_MASK   = 16'hEFFF;

   // ***********************************************************
   // Values after reset
   // ***********************************************************
   localparam logic [10:0] NP_FIELD_RESET   = 11'h001;
   localparam logic        MSG_PAGE_RESET   = 1'h1;
   localparam logic        LOCAL_NP_HW_RST  = 1'h1;
   localparam logic        LOCAL_NP_SW_RST  = 1'h0;
   localparam logic [15:0] WORD_ZERO        = 16'h0000;

   // ***********************************************************
   // State encodings
   // ***********************************************************
   typedef enum logic [1:0] {
      NGP_TX_IDLE  = 2'h1,
      NGP_TX_OFFER = 2'h2
   } ngp_tx_state_t;

   typedef enum logic [1:0] {
      NGP_P_READY = 2'h1,
      NGP_P_WAIT  = 2'h2
   } ngp_take_state_t;

endpackage : ngp_pkg

// file: verification/ngp_link_sva.sv
`timescale 1ns/1ps
module ngp_link_sva (
   input  wire logic        CLOCK_IN,     // Clock
   input  wire logic        RSTN_IN,      // Async reset, active low
   input  wire logic        SW_RESET_IN,  // Software reset
   input  wire logic        REG_WR_IN,    // Register write strobe
   input  wire logic [15:0] tx_word,      // Offered code word
   input  wire logic        tx_valid,     // Offer up
   input  wire logic        tx_taken      // Partner took word
);
   // ****************************************
   // Transmit side of the link
   // ****************************************
   default clocking cb @(posedge CLOCK_IN); endclocking
   default disable iff (!RSTN_IN);
   property p_rsvd_zero;
      tx_word[14] == 1'h0;
   endproperty
   a_rsvd_zero: assert property (p_rsvd_zero) else $error("tx bit 14 set");
   property p_flip;
      tx_taken && !SW_RESET_IN |=> tx_word[11] != $past(tx_word[11]);
   endproperty
   a_flip: assert property (p_flip) else $error("toggle did not flip");
   property p_hold;
      !tx_taken && !SW_RESET_IN |=> $stable(tx_word[11]);
   endproperty
   a_hold: assert property (p_hold) else $error("toggle moved untaken");
   // Write in the take cycle restarts the offer
   property p_drop;
      tx_taken && !REG_WR_IN && !SW_RESET_IN |=> !tx_valid;
   endproperty
   a_drop: assert property (p_drop) else $error("offer not dropped");
   property p_answer;
      $rose(tx_valid) |=> tx_taken;
   endproperty
   a_answer: assert property (p_answer) else $error("offer not taken");
   property p_taken_valid;
      tx_taken |-> $past(tx_valid);
   endproperty
   a_taken_valid: assert property (p_taken_valid) else $error("take without offer");
   property p_reset_word;
      $rose(RSTN_IN) |-> tx_word == 16'h2001 && !tx_valid;
   endproperty
   a_reset_word: assert property (p_reset_word) else $error("bad word after reset");
   property p_sw_word;
      SW_RESET_IN |=> tx_word == 16'h2001 && !tx_valid;
   endproperty
   a_sw_word: assert property (p_sw_word) else $error("bad word after sw reset");
endmodule : ngp_link_sva

// file: verification/testbench.sv
`timescale 1ns/1ps
module testbench;
   logic        clk, rstn, sw_reset, par_fault, reg_wr, reg_rd, reg_rvalid, ce;
   logic        an_enable, send, send_base, got_valid;
   logic [4:0]  reg_addr;
   logic [15:0] reg_wdata, reg_rdata, send_word, got_word;
   int          n_errors = 0;
   int          num_checks = 0;
   ngp_link_if link_if ();
   ngp_device ngp_device_inst (.CLOCK_IN(clk), .RSTN_IN(rstn), .CE_IN(ce),
      .SW_RESET_IN(sw_reset), .PAR_FAULT_IN(par_fault), .REG_ADDR_IN(reg_addr),
      .REG_WDATA_IN(reg_wdata), .REG_WR_IN(reg_wr), .REG_RD_IN(reg_rd),
      .REG_RDATA_OUT(reg_rdata), .REG_RVALID_OUT(reg_rvalid), .LINK(link_if.dev));
   ngp_partner ngp_partner_inst (.CLOCK_IN(clk), .RSTN_IN(rstn), .CE_IN(ce),
      .AN_ENABLE_IN(an_enable), .SEND_IN(send), .SEND_BASE_IN(send_base),
      .SEND_WORD_IN(send_word), .GOT_WORD_OUT(got_word), .GOT_VALID_OUT(got_valid),
      .LINK(link_if.part));
   ngp_link_sva ngp_link_sva_inst (.CLOCK_IN(clk), .RSTN_IN(rstn), .SW_RESET_IN(sw_reset),
      .REG_WR_IN(reg_wr), .tx_word(link_if.tx_word), .tx_valid(link_if.tx_valid),
      .tx_taken(link_if.tx_taken));
   // ****************************************
   // Shared bus tasks
   // ****************************************
   task automatic check(input string nm, input logic [15:0] exp, input logic [15:0] got);
      num_checks++;
      if (got !== exp) begin
         $display("[FAIL] %s expected %h seen %h", nm, exp, got);
         n_errors++;
      end
   endtask : check
   task automatic reg_write(input logic [4:0] a, input logic [15:0] d);
      @(negedge clk);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'h1;
      @(negedge clk);
      reg_wr = 1'h0;
   endtask : reg_write
   // Data sampled mid-cycle, one cycle after the strobe
   task automatic reg_read(input logic [4:0] a, input logic [15:0] exp);
      @(negedge clk);
      reg_addr = a;
      reg_rd = 1'h1;
      @(negedge clk);
      reg_rd = 1'h0;
      check($sformatf("rvalid %h", a), 16'h0001, {15'h0, reg_rvalid});
      check($sformatf("reg %h", a), exp, reg_rdata);
   endtask : reg_read
   task automatic send_page(input logic [15:0] w, input logic b);
      @(negedge clk);
      send_word = w;
      send_base = b;
      send = 1'h1;
      @(negedge clk);
      send = 1'h0;
      @(negedge clk);
   endtask : send_page
   task automatic tx_page(input logic [15:0] wd, input logic [15:0] eg, input logic [15:0] ea);
      int n;
      n = 0;
      // Next page is loaded only once the partner's page has arrived
      send_page(16'h5432, 1'h0);
      reg_read(5'h06, 16'h0017);
      reg_write(5'h07, wd);
      while (got_valid !== 1'h1 && n < 10) begin
         @(negedge clk);
         n++;
      end
      check("partner took", 16'h0001, {15'h0, got_valid});
      check("partner word", eg, got_word);
      reg_read(5'h07, ea);
   endtask : tx_page
   // ****************************************
   // Scenarios
   // ****************************************
   task automatic t_reset_values;
      reg_read(5'h05, 16'h0000);
      reg_read(5'h06, 16'h0004);
      reg_read(5'h07, 16'h2001);
      reg_read(5'h08, 16'h0000);
   endtask : t_reset_values
   task automatic t_base_pages;
      logic [15:0] w [3] = '{16'hFFFF, 16'h2C20, 16'h43E0};
      an_enable = 1'h1;
      par_fault = 1'h1;
      foreach (w[i]) begin
         send_page(w[i], 1'h1);
         reg_read(5'h05, w[i] & 16'hEFFF);
         reg_read(5'h06, {11'h0, 1'h1, w[i][15], 3'h7});
         reg_read(5'h06, {11'h0, 1'h1, w[i][15], 3'h5});
      end
   endtask : t_base_pages
   task automatic t_next_pages;
      send_page(16'hABCD, 1'h0);
      reg_read(5'h08, 16'hABCD);
      send_page(16'h5432, 1'h0);
      reg_read(5'h08, 16'h5432);
      reg_read(5'h05, 16'h43E0);
   endtask : t_next_pages
   task automatic t_transmit;
      tx_page(16'hFFFF, 16'hB7FF, 16'hBFFF);
      tx_page(16'h0000, 16'h0800, 16'h0000);
   endtask : t_transmit
   task automatic t_write_ignored;
      reg_write(5'h05, 16'h1234);
      reg_write(5'h08, 16'h1234);
      reg_read(5'h05, 16'h43E0);
      reg_read(5'h08, 16'h5432);
      reg_read(5'h1F, 16'h0000);
   endtask : t_write_ignored
   task automatic t_sw_reset;
      par_fault = 1'h0;
      @(negedge clk);
      sw_reset = 1'h1;
      @(negedge clk);
      sw_reset = 1'h0;
      reg_read(5'h05, 16'h0000);
      reg_read(5'h06, 16'h0001);
      reg_read(5'h07, 16'h2001);
      reg_read(5'h08, 16'h0000);
   endtask : t_sw_reset
   task automatic t_clock_enable;
      @(negedge clk);
      ce = 1'h0;
      reg_addr = 5'h07;
      reg_wdata = 16'h07FF;
      reg_wr = 1'h1;
      reg_rd = 1'h1;
      @(negedge clk);
      reg_wr = 1'h0;
      reg_rd = 1'h0;
      ce = 1'h1;
      check("rvalid frozen", 16'h0000, {15'h0, reg_rvalid});
      reg_read(5'h07, 16'h2001);
   endtask : t_clock_enable
   task automatic t_hw_reset;
      @(negedge clk);
      rstn = 1'h0;
      repeat (2) @(negedge clk);
      rstn = 1'h1;
      reg_read(5'h06, 16'h0004);
      reg_read(5'h07, 16'h2001);
   endtask : t_hw_reset
   task automatic test_done;
      if (n_errors == 0 && num_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : test_done
   initial begin
      clk = 1'h0;
      forever #2 clk = ~clk;
   end
   // Whole run needs well under a thousand cycles
   initial begin
      #20000;
      n_errors++;
      test_done();
   end
   initial begin
      {rstn, sw_reset, par_fault, reg_wr, reg_rd, an_enable, send, send_base} = 8'h00;
      reg_addr = 5'h00;
      ce = 1'h1;
      reg_wdata = 16'h0000;
      send_word = 16'h0000;
      repeat (10) @(posedge clk);
      @(negedge clk);
      rstn = 1'h1;
      t_reset_values();
      t_base_pages();
      t_next_pages();
      t_transmit();
      t_write_ignored();
      t_sw_reset();
      t_clock_enable();
      t_hw_reset();
      test_done();
   end
endmodule : testbench
